/* rtl/sft_pkg.sv */
package sft_pkg;
	// ---------------------------------------------------------------
	// register map
	// ---------------------------------------------------------------
	localparam logic [2:0] SFT_ADDR_DATA = 3'h0; // serial_data_reg
	localparam logic [2:0] SFT_ADDR_STA_A = 3'h1; // ctrl_status_a
	localparam logic [2:0] SFT_ADDR_CTL_B = 3'h2; // ctrl_status_b
	localparam logic [2:0] SFT_ADDR_CTL_C = 3'h3; // ctrl_status_c
	localparam logic [2:0] SFT_ADDR_BAUD_L = 3'h4; // baud_divisor_low
	localparam logic [2:0] SFT_ADDR_BAUD_H = 3'h5; // baud_divisor_high

	// ctrl_status_a fields
	localparam int SFT_A_TXC = 6; // tx_complete_flag
	localparam int SFT_A_UDRE = 5; // tx_buffer_empty_flag
	localparam int SFT_A_U2X = 1; // double_speed_sel
	// ctrl_status_b fields
	localparam int SFT_B_TX_ENABLE_BIT = 3; // tx_enable_bit
	localparam int SFT_B_SZ2 = 2; // char_size_sel bit 2
	localparam int SFT_B_TX_NINTH_BIT = 0; // tx_ninth_bit
	// ctrl_status_c fields
	localparam int SFT_C_SYNC = 6; // synchronous mode
	localparam int SFT_C_PMH = 5; // parity_mode_sel high
	localparam int SFT_C_PML = 4; // parity_mode_sel low
	localparam int SFT_C_STOP2 = 3; // two stop bits
	localparam int SFT_C_SZ1 = 2; // char_size_sel bit 1
	localparam int SFT_C_SZ0 = 1; // char_size_sel bit 0

	// reset values
	localparam logic [7:0] SFT_RST_B = 8'h00;
	localparam logic [7:0] SFT_RST_C = 8'h06; // 8 data bits
	localparam logic [11:0] SFT_RST_BAUD = 12'h000;

	// char size codes
	localparam logic [2:0] SFT_SZ_9 = 3'h7;
	localparam logic [3:0] SFT_BITS_BASE = 4'h5;
	localparam logic [3:0] SFT_BITS_NINE = 4'h9;
	localparam logic [3:0] SFT_BITS_EIGHT = 4'h8;

	// baud prescale per mode
	localparam logic [4:0] SFT_PRE_NORM = 5'h10;
	localparam logic [4:0] SFT_PRE_DBL = 5'h08;
	localparam logic [4:0] SFT_PRE_SYNC = 5'h02;

	// shared frame format, used by transmit and receive
	typedef struct packed {
		logic [2:0] charSize;
		logic [1:0] parityMode;
		logic twoStop;
		logic syncMode;
	} sft_format_type;

	typedef enum logic [2:0] {
		SFT_IDLE,
		SFT_START,
		SFT_DATA,
		SFT_PARITY,
		SFT_STOP1,
		SFT_STOP2
	} sft_state_type;
endpackage

/* rtl/sft_edge_sync.sv */
`timescale 1ns/1ps
// two-flop synchroniser with rising and falling edge pulses
module sft_edge_sync (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// pin
	input wire logic pinIn,
	// outputs
	output logic rise,
	output logic fall
);
	logic meta; // first stage, read only by stage two
	logic stable; // second stage
	logic last; // previous stable value

	// ---------------------------------------------------------------
	// synchroniser chain
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			meta <= 1'b0;
			stable <= 1'b0;
			last <= 1'b0;
		end else begin
			meta <= pinIn;
			stable <= meta;
			last <= stable;
		end
	end

	assign rise = stable & ~last;
	assign fall = ~stable & last;
endmodule

/* rtl/sft_transmitter.sv */
// Decided for this implementation: the plain strobed port and the register offsets.
`timescale 1ns/1ps
// Operation
// - start, 5-9 data, parity option, 1-2 stops
// - start bit then data LSB first
// - parity after data, before stop
// - back to back frame or idle high
// - one format shared by tx and rx
// - host must not change format mid-transfer
// - size field picks bits, parity field mode
// - stop select picks one or two stops
// - receiver checks only first stop bit
// - parity is xor of data, odd inverts
// - tx enable takes over output pin
// - sync mode: transfer clock times bits
// - data write loads single transmit buffer
// - buffer to shifter when idle or after stop
// - frame sent at divisor or external rate
// - unused upper data bits ignored
// - empty flag tracks buffer, write clears
// - complete flag set at end, write one clears
// - parity on when parity field top bit set
// - disable waits for shifter and buffer empty
module sft_transmitter
	import sft_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// register port
	input wire logic [2:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [7:0] regRdData,
	// transfer clock pin input (sync mode)
	input wire logic transferClockIn,
	// serial output pin
	output logic serialOut,
	output logic serialOutEn,
	// shared format toward the receive path
	output sft_format_type frameFormat,
	// receive path's first stop sample check
	input wire logic rxStopSample,
	input wire logic rxStopStrobe,
	output logic framingError
);
	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	logic [7:0] ctlB; // enable, size bit 2, ninth bit
	logic [7:0] ctlC; // mode, parity, stop, size
	logic doubleSpeed; // double_speed_sel
	logic [11:0] baudDiv; // 12-bit divisor
	logic txEnableBit; // tx_enable_bit as written
	logic txActive; // pin ownership, lags disable
	logic bufFull; // single-entry buffer occupied
	logic [8:0] bufData; // buffered character
	logic txComplete; // tx_complete_flag
	sft_state_type state; // shifter state
	logic [8:0] shiftReg; // data being shifted
	logic [3:0] bitCount; // data bits left
	logic parityAcc; // running xor of sent data
	logic bitTick; // one bit time elapsed
	logic [11:0] baudCnt; // baud down-counter
	logic baudTick; // divider output pulse
	logic [4:0] preCnt; // prescale counter
	logic xckRise; // synchronised pin edge
	logic frameEnd; // last stop bit finishing
	logic loadShift; // buffer moves into shifter
	logic dataWrite; // data register write
	logic [3:0] dataBits; // configured data bits
	logic [4:0] preLimit; // prescale for mode

	assign dataWrite = regWrite && regAddr == SFT_ADDR_DATA;

	// size field decode, used by the shifter and the mask
	function automatic logic [3:0] size_bits(input logic [2:0] code);
		if (code == SFT_SZ_9) begin
			return SFT_BITS_NINE;
		end else if (code[2]) begin
			return SFT_BITS_EIGHT; // reserved codes act as eight
		end else begin
			return SFT_BITS_BASE + {2'b00, code[1:0]};
		end
	endfunction

	// one shared format for both directions
	always_comb begin
		frameFormat.charSize = {ctlB[SFT_B_SZ2], ctlC[SFT_C_SZ1],
			ctlC[SFT_C_SZ0]};
		frameFormat.parityMode = {ctlC[SFT_C_PMH], ctlC[SFT_C_PML]};
		frameFormat.twoStop = ctlC[SFT_C_STOP2];
		frameFormat.syncMode = ctlC[SFT_C_SYNC];
	end
	assign dataBits = size_bits(frameFormat.charSize);

	// ---------------------------------------------------------------
	// control register writes
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			ctlB <= SFT_RST_B;
			ctlC <= SFT_RST_C;
			doubleSpeed <= 1'b0;
			baudDiv <= SFT_RST_BAUD;
		end else if (regWrite) begin
			// changes mid-frame corrupt traffic; host avoids them
			case (regAddr)
				SFT_ADDR_CTL_B: ctlB <= regWrData;
				SFT_ADDR_CTL_C: ctlC <= regWrData;
				SFT_ADDR_STA_A: doubleSpeed <= regWrData[SFT_A_U2X];
				SFT_ADDR_BAUD_L: baudDiv[7:0] <= regWrData;
				SFT_ADDR_BAUD_H: baudDiv[11:8] <= regWrData[3:0];
				default: ;
			endcase
		end
	end
	assign txEnableBit = ctlB[SFT_B_TX_ENABLE_BIT];

	// ---------------------------------------------------------------
	// baud generator and bit timing
	// ---------------------------------------------------------------
	sft_edge_sync u_xck (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.pinIn(transferClockIn),
		.rise(xckRise),
		.fall()
	);

	// down-counter reloads at zero or on a low byte write
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			baudCnt <= SFT_RST_BAUD;
		end else if (baudCnt == '0 ||
			(regWrite && regAddr == SFT_ADDR_BAUD_L)) begin
			baudCnt <= baudDiv;
		end else begin
			baudCnt <= baudCnt - 12'h001;
		end
	end
	assign baudTick = baudCnt == '0;

	// transmit divides the baud clock by 8 or 16; sync mode picks 2 but bits follow xckRise
	assign preLimit = frameFormat.syncMode ? SFT_PRE_SYNC :
		(doubleSpeed ? SFT_PRE_DBL : SFT_PRE_NORM);

	// prescaler restarts with each frame so the start bit is full
	always_ff @(posedge ref_clk) begin
		if (!rst_n || loadShift) begin
			preCnt <= '0;
		end else if (baudTick) begin
			preCnt <= (preCnt + 5'h01 >= preLimit) ? '0 : preCnt + 5'h01;
		end
	end

	// sync mode: bits advance on the transfer clock edge
	assign bitTick = frameFormat.syncMode ? xckRise :
		(baudTick && preCnt + 5'h01 >= preLimit);

	// ---------------------------------------------------------------
	// transmit buffer and flags
	// ---------------------------------------------------------------
	assign frameEnd = bitTick && ((state == SFT_STOP1 &&
		!frameFormat.twoStop) || state == SFT_STOP2);
	// load when idle, or right as the last stop ends
	// sync mode waits for a link edge, else the start bit is cut short
	assign loadShift = bufFull && txEnableBit && (frameEnd ||
		(state == SFT_IDLE && (!frameFormat.syncMode || bitTick)));

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			bufFull <= 1'b0;
			bufData <= '0;
		end else if (dataWrite) begin
			bufFull <= 1'b1;
			// ninth bit taken from the control bit at write time
			bufData <= {ctlB[SFT_B_TX_NINTH_BIT], regWrData};
		end else if (loadShift) begin
			bufFull <= 1'b0;
		end
	end

	// set wins over a one-write clear
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			txComplete <= 1'b0;
		end else if (frameEnd && !bufFull) begin
			txComplete <= 1'b1;
		end else if (regWrite && regAddr == SFT_ADDR_STA_A &&
			regWrData[SFT_A_TXC]) begin
			txComplete <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// shifter state machine
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			state <= SFT_IDLE;
			shiftReg <= '0;
			bitCount <= '0;
			parityAcc <= 1'b0;
		end else if (loadShift) begin
			state <= SFT_START;
			// mask bits above the configured size
			shiftReg <= bufData & ~(9'h1FF << dataBits);
			bitCount <= dataBits;
			parityAcc <= 1'b0;
		end else if (bitTick) begin
			case (state)
				SFT_START: state <= SFT_DATA;
				SFT_DATA: begin
					// lsb first
					parityAcc <= parityAcc ^ shiftReg[0];
					shiftReg <= {1'b0, shiftReg[8:1]};
					bitCount <= bitCount - 4'h1;
					if (bitCount == 4'h1) begin
						// parity only if top mode bit set
						state <= frameFormat.parityMode[1] ?
							SFT_PARITY : SFT_STOP1;
					end
				end
				SFT_PARITY: state <= SFT_STOP1;
				SFT_STOP1: state <= frameFormat.twoStop ?
					SFT_STOP2 : SFT_IDLE;
				SFT_STOP2: state <= SFT_IDLE;
				default: state <= SFT_IDLE;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// pin ownership and output
	// ---------------------------------------------------------------
	// release only once shifter and buffer are empty
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			txActive <= 1'b0;
		end else if (txEnableBit) begin
			txActive <= 1'b1;
		end else if (state == SFT_IDLE && !bufFull) begin
			txActive <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			serialOut <= 1'b1;
		end else begin
			case (state)
				SFT_START: serialOut <= 1'b0;
				SFT_DATA: serialOut <= shiftReg[0];
				// odd parity inverts the xor
				SFT_PARITY: serialOut <= parityAcc ^ frameFormat.parityMode[0];
				default: serialOut <= 1'b1; // stops and idle
			endcase
		end
	end
	assign serialOutEn = txActive;

	// ---------------------------------------------------------------
	// receive side stop check and read port
	// ---------------------------------------------------------------
	// only the first stop bit is checked
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			framingError <= 1'b0;
		end else if (rxStopStrobe) begin
			framingError <= ~rxStopSample;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			regRdData <= '0;
		end else if (regRead) begin
			case (regAddr)
				SFT_ADDR_STA_A: begin
					regRdData <= '0;
					regRdData[SFT_A_TXC] <= txComplete;
					regRdData[SFT_A_UDRE] <= ~bufFull;
					regRdData[SFT_A_U2X] <= doubleSpeed;
				end
				SFT_ADDR_CTL_B: regRdData <= ctlB;
				SFT_ADDR_CTL_C: regRdData <= ctlC;
				SFT_ADDR_BAUD_L: regRdData <= baudDiv[7:0];
				SFT_ADDR_BAUD_H: regRdData <= {4'h0, baudDiv[11:8]};
				default: regRdData <= '0;
			endcase
		end else begin
			regRdData <= '0;
		end
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	property p_start_low;
		@(posedge ref_clk) disable iff (!rst_n)
		$rose(state == SFT_START) |=> !serialOut;
	endproperty
	a_start_low: assert property (p_start_low)
		else $error("start bit not low");
	property p_write_fills;
		@(posedge ref_clk) disable iff (!rst_n)
		dataWrite |=> bufFull || state == SFT_START;
	endproperty
	a_write_fills: assert property (p_write_fills)
		else $error("data write did not fill buffer");
	property p_idle_high;
		@(posedge ref_clk) disable iff (!rst_n)
		txActive && state == SFT_IDLE && $past(state) == SFT_IDLE
			|-> serialOut;
	endproperty
	a_idle_high: assert property (p_idle_high)
		else $error("idle line not high");
	property p_load_idle;
		@(posedge ref_clk) disable iff (!rst_n)
		bufFull && txEnableBit && state == SFT_IDLE &&
			(!frameFormat.syncMode || bitTick) |=> state == SFT_START;
	endproperty
	a_load_idle: assert property (p_load_idle)
		else $error("buffer not moved to shifter");
	property p_no_parity;
		@(posedge ref_clk) disable iff (!rst_n)
		!frameFormat.parityMode[1] |-> state != SFT_PARITY;
	endproperty
	a_no_parity: assert property (p_no_parity)
		else $error("parity bit sent while disabled");
	property p_txc_set;
		@(posedge ref_clk) disable iff (!rst_n)
		frameEnd && !bufFull |=> txComplete;
	endproperty
	a_txc_set: assert property (p_txc_set)
		else $error("complete flag not set");
	property p_hold_pin;
		@(posedge ref_clk) disable iff (!rst_n)
		(state != SFT_IDLE || bufFull) && $past(txActive) |-> txActive;
	endproperty
	a_hold_pin: assert property (p_hold_pin)
		else $error("pin released with work pending");
	property p_one_stop;
		@(posedge ref_clk) disable iff (!rst_n)
		!frameFormat.twoStop && state == SFT_STOP1 && bitTick
			|=> state != SFT_STOP2;
	endproperty
	a_one_stop: assert property (p_one_stop)
		else $error("second stop with one selected");
	property p_fe;
		@(posedge ref_clk) disable iff (!rst_n)
		rxStopStrobe |=> framingError == !$past(rxStopSample);
	endproperty
	a_fe: assert property (p_fe)
		else $error("framing error mismatch");
endmodule

/* verification/sft_remote_rx.sv */
`timescale 1ns/1ps
// ---------------------------------------------
// remote peer: samples each bit at its middle
// ---------------------------------------------
module sft_remote_rx (
	// clock and bit length in clocks
	input wire logic ref_clk,
	input wire logic [7:0] bitCycles,
	// line as seen at the pin
	input wire logic serialLine,
	// format the peer expects
	input wire logic [3:0] dataBits,
	input wire logic parityOn,
	input wire logic parityOdd,
	// last frame seen
	output logic [8:0] rxData,
	output logic rxParityOk,
	output logic rxStopOk,
	output int frameCount,
	output longint lastGap
);
	longint lastStart; // start edge of previous frame
	logic par; // running parity
	// decoder, hunts for a start edge while idle
	initial begin
		frameCount = 0;
		lastStart = 0;
		lastGap = 0;
		rxData = 9'h000;
		rxParityOk = 1'b0;
		rxStopOk = 1'b0;
		forever begin
			@(negedge serialLine);
			lastGap = $time - lastStart;
			lastStart = $time;
			repeat (bitCycles / 2) @(posedge ref_clk);
			rxData = 9'h000;
			par = parityOdd; // odd parity starts from one
			// data arrive lsb first
			for (int i = 0; i < int'(dataBits); i++) begin
				repeat (bitCycles) @(posedge ref_clk);
				rxData[i] = serialLine;
				par = par ^ serialLine;
			end
			rxParityOk = 1'b1;
			// parity sits between data and stop
			if (parityOn) begin
				repeat (bitCycles) @(posedge ref_clk);
				rxParityOk = (serialLine === par);
			end
			// only the first stop is looked at
			repeat (bitCycles) @(posedge ref_clk);
			rxStopOk = (serialLine === 1'b1);
			frameCount++;
		end
	end
endmodule

/* verification/serial_frame_transmitter_tb.sv */
`timescale 1ns/1ps
module serial_frame_transmitter_tb
	import sft_pkg::*;
;
	// ---------------------------------------------
	// signals
	// ---------------------------------------------
	logic ref_clk;
	logic rst_n;
	logic [2:0] regAddr;
	logic [7:0] regWrData;
	logic regWrite;
	logic regRead;
	logic [7:0] regRdData;
	logic transferClockIn;
	logic serialOut;
	logic serialOutEn;
	sft_format_type frameFormat;
	logic rxStopSample;
	logic rxStopStrobe;
	logic framingError;
	logic serialPin; // pin with pull-up
	logic [3:0] peerBits; // peer format
	logic peerParOn;
	logic peerParOdd;
	logic [7:0] peerCyc; // peer clocks per bit
	logic [8:0] rxData;
	logic rxParityOk;
	logic rxStopOk;
	int frameCount;
	longint lastGap;
	int badCount;
	int cmpCount;
	logic xckRun; // link clock runs only around frames
	logic [7:0] rd;
	logic [2:0] sz;
	logic [1:0] pm;
	logic st;
	logic [8:0] d9;
	int n;
	logic [2:0] szTab [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
	logic [1:0] pmTab [3] = '{2'h0, 2'h2, 2'h3};
	// released pin floats high
	assign serialPin = serialOutEn ? serialOut : 1'b1;

	sft_transmitter u_sft_transmitter (
		.ref_clk(ref_clk), .rst_n(rst_n), .regAddr(regAddr),
		.regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
		.regRdData(regRdData), .transferClockIn(transferClockIn),
		.serialOut(serialOut), .serialOutEn(serialOutEn),
		.frameFormat(frameFormat), .rxStopSample(rxStopSample),
		.rxStopStrobe(rxStopStrobe), .framingError(framingError)
	);
	sft_remote_rx u_sft_remote_rx (
		.ref_clk(ref_clk), .bitCycles(peerCyc), .serialLine(serialPin),
		.dataBits(peerBits),
		.parityOn(peerParOn), .parityOdd(peerParOdd), .rxData(rxData),
		.rxParityOk(rxParityOk), .rxStopOk(rxStopOk),
		.frameCount(frameCount), .lastGap(lastGap)
	);

	// ---------------------------------------------
	// clocks and watchdog
	// ---------------------------------------------
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end
	// 400 ns link clock, edges fall on ref_clk falling edges
	initial begin
		transferClockIn = 1'b0;
		forever begin
			#200;
			if (xckRun) transferClockIn = ~transferClockIn;
		end
	end
	// run takes some 4000 cycles; this is ten times that
	initial begin
		repeat (40000) @(posedge ref_clk);
		badCount++;
		finishTest();
	end

	// ---------------------------------------------
	// tasks
	// ---------------------------------------------
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		cmpCount++;
		if (got !== exp) begin
			badCount++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one-cycle write strobe
	task automatic regWr(input logic [2:0] a, input logic [7:0] d);
		regAddr <= a;
		regWrData <= d;
		regWrite <= 1'b1;
		@(posedge ref_clk);
		regWrite <= 1'b0;
		// one idle edge: the next call never re-raises the strobe at once
		@(posedge ref_clk);
	endtask
	// data stand only in the cycle after the strobe
	task automatic regRd(input logic [2:0] a, output logic [7:0] d);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge ref_clk);
		regRead <= 1'b0;
		@(negedge ref_clk);
		d = regRdData;
		@(posedge ref_clk);
	endtask
	// poll a status bit, bounded
	task automatic waitFlag(input int b);
		rd = 8'h00;
		for (int i = 0; i < 300 && rd[b] !== 1'b1; i++) regRd(SFT_ADDR_STA_A, rd);
		check(16'(rd[b]), 16'h0001);
	endtask
	// wait for the peer to count a frame
	task automatic waitFrame(input int m);
		for (int i = 0; i < 400 && frameCount < m; i++) @(posedge ref_clk);
		check(16'(frameCount), 16'(m));
	endtask
	task automatic finishTest();
		if (badCount == 0 && cmpCount > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// ---------------------------------------------
	// main sequence
	// ---------------------------------------------
	initial begin
		rst_n = 1'b0;
		regAddr = 3'h0;
		regWrData = 8'h00;
		regWrite = 1'b0;
		regRead = 1'b0;
		peerCyc = 8'd8;
		rxStopSample = 1'b1;
		rxStopStrobe = 1'b0;
		xckRun = 1'b0;
		peerBits = 4'h8;
		peerParOn = 1'b0;
		peerParOdd = 1'b0;
		badCount = 0;
		cmpCount = 0;
		repeat (12) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		// reset values, unmapped read gives zero
		regRd(SFT_ADDR_CTL_B, rd);
		check(16'(rd), 16'(SFT_RST_B));
		regRd(SFT_ADDR_CTL_C, rd);
		check(16'(rd), 16'(SFT_RST_C));
		regRd(SFT_ADDR_STA_A, rd);
		check(16'(rd), 16'h0020);
		regRd(3'h7, rd);
		check(16'(rd), 16'h0000);
		check(16'(serialOutEn), 16'h0000);
		// divisor then double speed then enable, 8 clocks per bit
		regWr(SFT_ADDR_BAUD_H, 8'h00);
		regWr(SFT_ADDR_BAUD_L, 8'h00);
		regWr(SFT_ADDR_STA_A, 8'h02);
		regWr(SFT_ADDR_CTL_B, 8'h08);
		@(negedge ref_clk);
		check(16'({serialOutEn, serialPin}), 16'h0003);
		@(posedge ref_clk);
		// every size, parity and stop count
		for (int k = 0; k < 30; k++) begin
			sz = szTab[k % 5];
			pm = pmTab[(k / 5) % 3];
			st = (k >= 15);
			d9 = 9'h1a5 ^ 9'(k * 37);
			peerBits <= (sz == SFT_SZ_9) ? 4'h9 : 4'h5 + {2'h0, sz[1:0]};
			peerParOn <= pm[1];
			peerParOdd <= pm[0];
			regWr(SFT_ADDR_CTL_C, {2'h0, pm, st, sz[1:0], 1'b0});
			regWr(SFT_ADDR_CTL_B, {4'h0, 1'b1, sz[2], 1'b0, d9[8]});
			check(16'(frameFormat), 16'({sz, pm, st, 1'b0}));
			n = frameCount;
			regWr(SFT_ADDR_DATA, d9[7:0]);
			waitFrame(n + 1);
			check(16'(rxData), 16'(sz == SFT_SZ_9 ? d9 :
				{1'b0, d9[7:0] & (8'hff >> (2'd3 - sz[1:0]))}));
			check(16'(rxParityOk), 16'h0001);
			check(16'(rxStopOk), 16'h0001);
			waitFlag(SFT_A_TXC);
			regWr(SFT_ADDR_STA_A, 8'h42);
		end
		// back to back, even parity, two stops
		peerBits <= 4'h8;
		peerParOn <= 1'b1;
		peerParOdd <= 1'b0;
		regWr(SFT_ADDR_CTL_C, 8'h2e);
		regWr(SFT_ADDR_CTL_B, 8'h08);
		n = frameCount;
		regWr(SFT_ADDR_DATA, 8'h3c);
		waitFlag(SFT_A_UDRE);
		regWr(SFT_ADDR_DATA, 8'hc1);
		regRd(SFT_ADDR_STA_A, rd);
		check(16'(rd[SFT_A_UDRE]), 16'h0000);
		waitFrame(n + 1);
		check(16'(rxData), 16'h003c);
		waitFrame(n + 2);
		check(16'(rxData), 16'h00c1);
		check(16'(lastGap), 16'd4800);
		waitFlag(SFT_A_TXC);
		regWr(SFT_ADDR_STA_A, 8'h42);
		// disable in mid-frame: pin kept until frame ends
		n = frameCount;
		regWr(SFT_ADDR_DATA, 8'h5a);
		regWr(SFT_ADDR_CTL_B, 8'h00);
		repeat (20) @(posedge ref_clk);
		@(negedge ref_clk);
		check(16'(serialOutEn), 16'h0001);
		waitFrame(n + 1);
		check(16'(rxData), 16'h005a);
		repeat (40) @(posedge ref_clk);
		@(negedge ref_clk);
		check(16'(serialOutEn), 16'h0000);
		// framing error from the first stop sample only
		@(posedge ref_clk);
		rxStopSample <= 1'b0;
		rxStopStrobe <= 1'b1;
		@(posedge ref_clk);
		rxStopStrobe <= 1'b0;
		@(negedge ref_clk);
		check(16'(framingError), 16'h0001);
		@(posedge ref_clk);
		rxStopSample <= 1'b1;
		rxStopStrobe <= 1'b1;
		@(posedge ref_clk);
		rxStopStrobe <= 1'b0;
		@(negedge ref_clk);
		check(16'(framingError), 16'h0000);
		@(posedge ref_clk);
		// normal speed, divisor one: 32 clocks per bit
		peerCyc <= 8'd32;
		peerParOn <= 1'b0;
		regWr(SFT_ADDR_STA_A, 8'h40);
		regWr(SFT_ADDR_BAUD_L, 8'h01);
		regRd(SFT_ADDR_BAUD_L, rd);
		check(16'(rd), 16'h0001);
		regWr(SFT_ADDR_CTL_C, 8'h06);
		regWr(SFT_ADDR_CTL_B, 8'h08);
		n = frameCount;
		regWr(SFT_ADDR_DATA, 8'h96);
		waitFrame(n + 1);
		check(16'(rxData), 16'h0096);
		waitFlag(SFT_A_TXC);
		regWr(SFT_ADDR_STA_A, 8'h40);
		// synchronous mode: link clock times the bits
		peerCyc <= 8'd8;
		peerParOn <= 1'b0;
		regWr(SFT_ADDR_CTL_C, 8'h46);
		regWr(SFT_ADDR_CTL_B, 8'h08);
		xckRun = 1'b1;
		n = frameCount;
		regWr(SFT_ADDR_DATA, 8'hc3);
		waitFrame(n + 1);
		check(16'(rxData), 16'h00c3);
		waitFlag(SFT_A_TXC);
		xckRun = 1'b0;
		finishTest();
	end
endmodule
